// >>> core/sarseq_defines.svh
// sarseq_defines.svh: offsets, field positions, reset values and timing
// counts for the converter sequencer; assumes a 125 MHz pclk
`ifndef SARSEQ_DEFINES_SVH
`define SARSEQ_DEFINES_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define SARSEQ_OFF_CTRL 12'h000
`define SARSEQ_OFF_TIMING 12'h004
`define SARSEQ_OFF_CLKDIV 12'h008
`define SARSEQ_OFF_STATUS 12'h00c
`define SARSEQ_OFF_INT_STAT 12'h010
`define SARSEQ_OFF_INT_MASK 12'h014
`define SARSEQ_OFF_RESULT 12'h018
`define SARSEQ_OFF_CH_RESULT 12'h040
`define SARSEQ_OFF_CH_LAST 12'h06c

// ************************************************************
// field positions
// ************************************************************
`define SARSEQ_CTRL_EN 0
`define SARSEQ_CTRL_MODE_LO 1
`define SARSEQ_CTRL_CONT 3
`define SARSEQ_CTRL_CH_LO 4
`define SARSEQ_TIM_SAMPLE_LO 8
`define SARSEQ_INT_CONV 0
`define SARSEQ_INT_SWEEP 1

// ************************************************************
// sizes, reset values and timing
// ************************************************************
`define SARSEQ_RES_W 10
`define SARSEQ_CONV_TICKS 8'd12
`define SARSEQ_INTA_TICKS 8'd2
`define SARSEQ_AUTO_LAST 5'h0b
`define SARSEQ_AUTO_CH 12
`define SARSEQ_EN_DLY_RST 8'h04
`define SARSEQ_SAMPLE_RST 8'h04
`define SARSEQ_PCLK_NS 8
`define SARSEQ_CH_CONV_NS 63330
// one round-robin channel spends sample, convert and pulse ticks
`define SARSEQ_CLKDIV_RST \
  (`SARSEQ_CH_CONV_NS / (`SARSEQ_PCLK_NS * (4 + 12 + 2)))

`endif

// >>> core/sarseq_pkg.sv
// sarseq_pkg: types shared by the converter sequencer
// assumes sarseq_defines.svh supplies the numbers
`default_nettype none

package sarseq_pkg;
  // gray codes along idle-delay-sample-convert-pulse
  typedef enum logic [2:0] {
    SARSEQ_OFF = 3'h0,
    SARSEQ_EN_DLY = 3'h1,
    SARSEQ_SAMPLE = 3'h3,
    SARSEQ_CONVERT = 3'h2,
    SARSEQ_PULSE = 3'h6,
    SARSEQ_WAIT = 3'h7
  } sarseq_state_t;

  typedef enum logic [1:0] {
    SARSEQ_SINGLE = 2'h0,
    SARSEQ_ROUND = 2'h1,
    SARSEQ_ONCE = 2'h2,
    SARSEQ_RSVD = 2'h3
  } sarseq_mode_t;

  // drive bundle towards the analog multiplexer and dac
  typedef struct packed {
    logic sample;
    logic div_bypass;
    logic [4:0] channel;
    logic [9:0] dac_code;
  } sarseq_analog_t;
endpackage : sarseq_pkg

`default_nettype wire

// >>> core/sarseq_core.sv
// sarseq_core: apb register file, phase sequencer and sar loop
// assumes a comparator pin from the analog side, pclk at 125 MHz,
// and a converter clock divider of at least 4 so the synchroniser settles
//
// Overview of operation
// - ten-bit successive approximation per conversion
// - voltages divided, current channels bypass divider
// - 32 channels, only 0-11 auto sequenced
// - one of three modes at a time
// - single mode converts once, then interrupts
// - enable delay, then programmable sample window
// - conversion phase lasts twelve converter clocks
// - result readable, interrupt pulse two clocks
// - continuous single restarts after interrupt pulse
// - round robin 0 to 11, repeating
// - results readable anytime without disturbing sequence
// - new round robin result overwrites old
// - about 63.33 us per channel conversion
// - one-time sweep halts, single interrupt after
`include "sarseq_defines.svh"
`default_nettype none

module sarseq_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comp_in,
  output sarseq_pkg::sarseq_analog_t analog,
  output logic core_done_pulse,
  output logic irq
);
  import sarseq_pkg::*;

  // ************************************************************
  // decode helpers
  // ************************************************************
  // current-sense channels and temperature skip the divider
  // divider bypass
  function automatic logic no_divider(input logic [4:0] ch);
    no_divider = (ch == 5'h00) || (ch == 5'h03) || (ch == 5'h05) ||
                 (ch == 5'h07) || (ch == 5'h09);
  endfunction : no_divider

  // true when a byte offset lies inside the per-channel result window
  function automatic logic in_ch_window(input logic [11:0] a);
    in_ch_window = (a >= `SARSEQ_OFF_CH_RESULT) && (a <= `SARSEQ_OFF_CH_LAST);
  endfunction : in_ch_window

  // ************************************************************
  // registers and state
  // ************************************************************
  logic ctrl_en;
  sarseq_mode_t ctrl_mode;
  logic ctrl_cont;
  logic [4:0] ctrl_ch;
  logic [7:0] en_dly;
  logic [7:0] sample_win;
  logic [15:0] clk_div;
  logic [1:0] int_stat;
  logic [1:0] int_mask;
  logic [9:0] last_result;
  logic [4:0] last_ch;
  logic [9:0] ch_result [`SARSEQ_AUTO_CH];
  logic start_pend;
  sarseq_state_t state;
  logic [15:0] div_cnt;
  logic tick;
  logic [7:0] ph_cnt;
  logic [4:0] cur_ch;
  logic [9:0] sar;
  logic comp_meta;
  logic comp_sync;
  logic [1:0] ev_set;
  logic wr_acc;
  logic setup;
  logic ctrl_wr;
  logic [1:0] int_clr;
  logic phase_end;
  logic [7:0] phase_len;
  logic sweep_last;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign ctrl_wr = wr_acc && (paddr == `SARSEQ_OFF_CTRL);
  assign int_clr = (wr_acc && (paddr == `SARSEQ_OFF_INT_STAT)) ? pwdata[1:0] : 2'h0;
  assign pready = 1'b1;
  // unmapped addresses answer with an error, no stall ever
  assign pslverr = psel && penable && !(
    (paddr == `SARSEQ_OFF_CTRL) || (paddr == `SARSEQ_OFF_TIMING) ||
    (paddr == `SARSEQ_OFF_CLKDIV) || (paddr == `SARSEQ_OFF_STATUS) ||
    (paddr == `SARSEQ_OFF_INT_STAT) || (paddr == `SARSEQ_OFF_INT_MASK) ||
    (paddr == `SARSEQ_OFF_RESULT) ||
    (in_ch_window(paddr) && (paddr[1:0] == 2'h0)));

  // ************************************************************
  // register writes
  // ************************************************************
  // control word: enable, mode, continuous flag, channel select
  // mode select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en <= 1'b0;
      ctrl_mode <= SARSEQ_SINGLE;
      ctrl_cont <= 1'b0;
      ctrl_ch <= 5'h00;
    end else if (ctrl_wr) begin
      ctrl_en <= pwdata[`SARSEQ_CTRL_EN];
      ctrl_mode <= sarseq_mode_t'(pwdata[`SARSEQ_CTRL_MODE_LO +: 2]);
      ctrl_cont <= pwdata[`SARSEQ_CTRL_CONT];
      ctrl_ch <= pwdata[`SARSEQ_CTRL_CH_LO +: 5];
    end
  end

  // timing, divider and mask words
  // default divider paces each channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_dly <= `SARSEQ_EN_DLY_RST;
      sample_win <= `SARSEQ_SAMPLE_RST;
      clk_div <= 16'(`SARSEQ_CLKDIV_RST);
      int_mask <= 2'h0;
    end else if (wr_acc) begin
      if (paddr == `SARSEQ_OFF_TIMING) begin
        en_dly <= pwdata[7:0];
        sample_win <= pwdata[`SARSEQ_TIM_SAMPLE_LO +: 8];
      end
      if (paddr == `SARSEQ_OFF_CLKDIV) begin
        clk_div <= pwdata[15:0];
      end
      if (paddr == `SARSEQ_OFF_INT_MASK) begin
        int_mask <= pwdata[1:0];
      end
    end
  end

  // sticky events, a set in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= 2'h0;
    end else begin
      int_stat <= (int_stat & ~int_clr) | ev_set;
    end
  end

  assign irq = |(int_stat & int_mask);

  // ************************************************************
  // register reads
  // ************************************************************
  // read data is captured in setup so the access phase never waits
  // reads never stall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= 32'h0000_0000;
      unique case (1'b1)
        (paddr == `SARSEQ_OFF_CTRL):
          prdata <= {23'h0, ctrl_ch, ctrl_cont, ctrl_mode, ctrl_en};
        (paddr == `SARSEQ_OFF_TIMING): prdata <= {16'h0, sample_win, en_dly};
        (paddr == `SARSEQ_OFF_CLKDIV): prdata <= {16'h0, clk_div};
        (paddr == `SARSEQ_OFF_STATUS): prdata <= {23'h0, cur_ch, start_pend, 3'(state)};
        (paddr == `SARSEQ_OFF_INT_STAT): prdata <= {30'h0, int_stat};
        (paddr == `SARSEQ_OFF_INT_MASK): prdata <= {30'h0, int_mask};
        (paddr == `SARSEQ_OFF_RESULT): prdata <= {17'h0, last_ch, last_result};
        // misaligned window reads are refused and must return zero
        (in_ch_window(paddr) && (paddr[1:0] == 2'h0)):
          prdata <= {22'h0, ch_result[4'(paddr[5:2])]};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // converter clock and comparator
  // ************************************************************
  // a slow tick keeps the sar loop well behind the synchroniser latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
    end else if (tick || (state == SARSEQ_OFF)) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  assign tick = (div_cnt + 16'h0001 >= clk_div);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= comp_in;
      comp_sync <= comp_meta;
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  // length of each timed phase in converter clocks
  // delay and sample
  always_comb begin
    unique case (state)
      SARSEQ_EN_DLY: phase_len = en_dly;
      SARSEQ_SAMPLE: phase_len = sample_win;
      SARSEQ_CONVERT: phase_len = `SARSEQ_CONV_TICKS;
      SARSEQ_PULSE: phase_len = `SARSEQ_INTA_TICKS;
      default: phase_len = 8'h01;
    endcase
  end

  assign phase_end = tick && (ph_cnt + 8'h01 >= phase_len);
  assign sweep_last = (cur_ch == `SARSEQ_AUTO_LAST);

  // a select written while enabled arms single and one-time runs
  // select starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_pend <= 1'b0;
    end else if (ctrl_wr && pwdata[`SARSEQ_CTRL_EN]) begin
      start_pend <= 1'b1;
    end else if ((state == SARSEQ_WAIT) || !ctrl_en) begin
      start_pend <= 1'b0;
    end
  end

  // phase counter restarts on every phase change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_cnt <= 8'h00;
    end else if (phase_end || (state == SARSEQ_OFF) || (state == SARSEQ_WAIT)) begin
      ph_cnt <= 8'h00;
    end else if (tick) begin
      ph_cnt <= ph_cnt + 8'h01;
    end
  end

  // main phase machine
  // disable aborts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SARSEQ_OFF;
      cur_ch <= 5'h00;
    end else if (!ctrl_en) begin
      state <= SARSEQ_OFF;
    end else begin
      unique case (state)
        SARSEQ_OFF: state <= SARSEQ_EN_DLY;
        SARSEQ_EN_DLY: if (phase_end) state <= SARSEQ_WAIT;
        SARSEQ_WAIT: begin
          if (ctrl_mode == SARSEQ_ROUND || ctrl_mode == SARSEQ_ONCE) begin
            if (ctrl_mode == SARSEQ_ROUND || start_pend) begin
              cur_ch <= 5'h00;
              state <= SARSEQ_SAMPLE;
            end
          end else if (start_pend) begin
            cur_ch <= ctrl_ch;
            state <= SARSEQ_SAMPLE;
          end
        end
        SARSEQ_SAMPLE: if (phase_end) state <= SARSEQ_CONVERT;
        SARSEQ_CONVERT: if (phase_end) state <= SARSEQ_PULSE;
        SARSEQ_PULSE: begin
          if (phase_end) begin
            if (ctrl_mode == SARSEQ_ROUND) begin
              cur_ch <= sweep_last ? 5'h00 : cur_ch + 5'h01;
              state <= SARSEQ_SAMPLE;
            end else if (ctrl_mode == SARSEQ_ONCE) begin
              cur_ch <= cur_ch + 5'h01;
              state <= sweep_last ? SARSEQ_WAIT : SARSEQ_SAMPLE;
            end else begin
              state <= ctrl_cont ? SARSEQ_SAMPLE : SARSEQ_WAIT;
            end
          end
        end
        default: state <= SARSEQ_OFF;
      endcase
    end
  end

  // successive approximation: tick 0 trials the msb, ticks 1-10 decide
  // one bit each and trial the next, tick 11 hands the word over
  // ten-bit search
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar <= 10'h000;
    end else if (state != SARSEQ_CONVERT) begin
      sar <= 10'h000;
    end else if (tick) begin
      if (ph_cnt == 8'h00) begin
        sar <= 10'h200;
      end else if (ph_cnt <= 8'h0a) begin
        for (int b = 0; b < `SARSEQ_RES_W; b++) begin
          if (b == 10 - int'(ph_cnt)) begin
            sar[b] <= comp_sync;
            if (b > 0) sar[b - 1] <= 1'b1;
          end
        end
      end
    end
  end

  // results land as the convert phase closes
  // result readable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_result <= 10'h000;
      last_ch <= 5'h00;
    end else if ((state == SARSEQ_CONVERT) && phase_end) begin
      last_result <= sar;
      last_ch <= cur_ch;
    end
  end

  for (genvar g = 0; g < `SARSEQ_AUTO_CH; g++) begin : g_ch_res
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ch_result[g] <= 10'h000;
      end else if ((state == SARSEQ_CONVERT) && phase_end && (cur_ch == 5'(g))) begin
        ch_result[g] <= sar;
      end
    end
  end

  // ************************************************************
  // outputs and events
  // ************************************************************
  // one-time sweeps only pulse after the final channel; the pulse is
  // launched as convert closes so it spans exactly the two pulse ticks
  // two-clock pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_done_pulse <= 1'b0;
    end else begin
      core_done_pulse <= ctrl_en &&
        (((state == SARSEQ_CONVERT) && phase_end) ||
         ((state == SARSEQ_PULSE) && !phase_end)) &&
        ((ctrl_mode != SARSEQ_ONCE) || sweep_last);
    end
  end

  assign ev_set[`SARSEQ_INT_CONV] = (state == SARSEQ_CONVERT) && phase_end;
  assign ev_set[`SARSEQ_INT_SWEEP] = (state == SARSEQ_PULSE) && phase_end &&
    (ctrl_mode == SARSEQ_ONCE) && sweep_last;

  // analog drive bundle is registered to avoid mux glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog <= '0;
    end else begin
      analog.sample <= (state == SARSEQ_SAMPLE);
      analog.div_bypass <= no_divider(cur_ch);
      analog.channel <= cur_ch;
      analog.dac_code <= sar;
    end
  end
endmodule : sarseq_core

`default_nettype wire

// >>> verification/sarseq_core_sva.sv
// sarseq_core_sva: port checker bound onto sarseq_core
// assumes CLKDIV of 4 or more, so one converter tick spans 4+ pclk
`default_nettype none
module sarseq_core_sva import sarseq_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic comp_in,
  input wire sarseq_analog_t analog,
  input wire logic core_done_pulse,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ***
  // bus and sequencer checks
  // ***
  a_ready_always: assert property (pready) else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  a_err_no_data: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("data on error");
  a_rdata_holds: assert property (!$past(psel && !penable) |-> $stable(prdata))
    else $error("prdata moved");
  a_done_width: assert property ($rose(core_done_pulse) |-> core_done_pulse [*6])
    else $error("done pulse short");
  a_done_ends: assert property ($rose(core_done_pulse) |-> ##[6:1000] !core_done_pulse)
    else $error("done pulse stuck");
  a_conv_gap: assert property ($fell(analog.sample) |-> !core_done_pulse [*8])
    else $error("convert too short");
  a_chan_steady: assert property (analog.sample && $past(analog.sample)
    |-> $stable(analog.channel)) else $error("channel moved in sample");
  a_pulse_idle: assert property (core_done_pulse |-> !analog.sample)
    else $error("sample during pulse");
  a_reset_quiet: assert property (disable iff (1'b0)
    !presetn |-> analog == '0 && !core_done_pulse && !irq) else $error("busy in reset");
  // main scenarios seen
  cover property ($rose(core_done_pulse));
  cover property ($rose(irq));
  cover property (pslverr);
endmodule : sarseq_core_sva

bind sarseq_core sarseq_core_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .comp_in, .analog, .core_done_pulse, .irq);
`default_nettype wire

// >>> verification/sarseq_afe_model.sv
// sarseq_afe_model: analog mux and comparator stand-in
// assumes the bench loads level[] before conversions start
`default_nettype none
module sarseq_afe_model import sarseq_pkg::*; (
  input wire sarseq_analog_t analog,
  output logic comp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] level [32];
  assign comp_in = (level[analog.channel] >= analog.dac_code);
endmodule : sarseq_afe_model
`default_nettype wire

// >>> verification/sarseq_core_tb.sv
// sarseq_core_tb: self-checking bench for sarseq_core
// assumes sarseq_afe_model on the analog side and CLKDIV cut to 4
`include "sarseq_defines.svh"
`default_nettype none
module sarseq_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, comp_in, core_done_pulse, irq, er;
  logic dprev = 1'b0;
  sarseq_pkg::sarseq_analog_t analog;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  int npulse = 0;
  int dlen = 0;
  int n0;
  int exp_ch[$];
  int sc[3] = '{12, 31, 13};

  // 125 MHz clock
  always #4 pclk = ~pclk;

  sarseq_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .comp_in, .analog, .core_done_pulse, .irq);
  sarseq_afe_model afe (.analog, .comp_in);

  // pulse count and hang limit, far above the ~3k cycles needed
  always @(posedge pclk) begin
    dprev <= core_done_pulse;
    dlen <= (core_done_pulse === 1'b1) ? dlen + 1 : 0;
    cyc <= cyc + 1;
    if (core_done_pulse === 1'b1 && dprev === 1'b0)
      npulse <= npulse + 1;
    // two converter ticks of four pclk each
    if (core_done_pulse !== 1'b1 && dprev === 1'b1)
      chk(32'(dlen), 32'(`SARSEQ_INTA_TICKS) * 32'h4, "pulse width");
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // apb transfer; holds everything until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // done pulses: channel, divider bypass, stored result
  task automatic wait_done(input int n);
    int e;
    repeat (n) begin
      do @(posedge pclk); while (!(core_done_pulse === 1'b1 && dprev === 1'b0));
      e = exp_ch.pop_front();
      chk(32'(analog.channel), 32'(e), "channel");
      chk(32'(analog.div_bypass), 32'(e inside {0, 3, 5, 7, 9}), "bypass");
      if (e < 12) begin
        apb(1'b0, 12'(`SARSEQ_OFF_CH_RESULT + 4 * e), 32'h0);
        chk(rd & 32'h3ff, 32'(afe.level[e]), "ch result");
      end
    end
  endtask : wait_done

  initial begin
    // a real falling edge so the async reset acts before the first clock
    presetn <= 1'b0;
    void'($urandom(28));
    for (int i = 0; i < 32; i++)
      afe.level[i] = 10'($urandom_range(1023, 0));
    sc[2] = $urandom_range(30, 13);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SARSEQ_OFF_TIMING, 32'h0);
    chk(rd, {16'h0, `SARSEQ_SAMPLE_RST, `SARSEQ_EN_DLY_RST}, "timing rst");
    apb(1'b0, `SARSEQ_OFF_CLKDIV, 32'h0);
    chk(rd, 32'(`SARSEQ_CLKDIV_RST), "clkdiv rst");
    apb(1'b0, 12'h0f0, 32'h0);
    chk(32'(er), 32'h1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    $display("test reset values done");
    apb(1'b1, `SARSEQ_OFF_CLKDIV, 32'h4);
    apb(1'b1, `SARSEQ_OFF_INT_MASK, 32'h1);
    // div2 pin channel taken first, as for a data pin
    for (int k = 0; k < 3; k++) begin
      exp_ch.push_back(sc[k]);
      apb(1'b1, `SARSEQ_OFF_CTRL, 32'(sc[k] << 4) | 32'h1);
      wait_done(1);
      do @(posedge pclk); while (irq !== 1'b1);
      apb(1'b0, `SARSEQ_OFF_RESULT, 32'h0);
      chk(rd, 32'({5'(sc[k]), afe.level[sc[k]]}), "result");
      apb(1'b0, `SARSEQ_OFF_INT_STAT, 32'h0);
      chk(rd, 32'h1, "conv flag");
      apb(1'b1, `SARSEQ_OFF_INT_MASK, 32'h0);
      @(posedge pclk);
      chk(32'(irq), 32'h0, "masked irq");
      apb(1'b1, `SARSEQ_OFF_INT_MASK, 32'h1);
      @(posedge pclk);
      chk(32'(irq), 32'h1, "unmasked irq");
      apb(1'b1, `SARSEQ_OFF_INT_STAT, 32'h1);
      @(posedge pclk);
      chk(32'(irq), 32'h0, "cleared irq");
      apb(1'b1, `SARSEQ_OFF_CTRL, 32'h0);
    end
    $display("test single done");
    exp_ch = '{5, 5};
    apb(1'b1, `SARSEQ_OFF_CTRL, 32'h59);
    wait_done(2);
    do @(posedge pclk); while (analog.sample !== 1'b1);
    apb(1'b1, `SARSEQ_OFF_CTRL, 32'h0);
    n0 = npulse;
    repeat (200) @(posedge pclk);
    chk(32'(npulse - n0), 32'h0, "abort pulses");
    apb(1'b0, `SARSEQ_OFF_STATUS, 32'h0);
    chk(rd & 32'h7, 32'h0, "abort idle");
    $display("test continuous and abort done");
    // averaging fixed at one sample, nothing to program
    for (int i = 0; i < 13; i++)
      exp_ch.push_back(i % 12);
    apb(1'b1, `SARSEQ_OFF_CTRL, 32'h3);
    wait_done(12);
    for (int i = 0; i < 12; i++)
      afe.level[i] = 10'($urandom_range(1023, 0));
    wait_done(1);
    // let the pulse finish so its width check sees a whole pulse
    do @(posedge pclk); while (core_done_pulse !== 1'b0);
    apb(1'b1, `SARSEQ_OFF_CTRL, 32'h0);
    // misaligned window read while channel 0 holds a fresh result
    apb(1'b0, 12'(`SARSEQ_OFF_CH_RESULT + 2), 32'h0);
    chk(32'(er), 32'h1, "misaligned err");
    chk(rd, 32'h0, "misaligned data");
    $display("test round robin done");
    apb(1'b1, `SARSEQ_OFF_INT_STAT, 32'h3);
    apb(1'b1, `SARSEQ_OFF_INT_MASK, 32'h2);
    exp_ch.push_back(11);
    n0 = npulse;
    apb(1'b1, `SARSEQ_OFF_CTRL, 32'h5);
    wait_done(1);
    do @(posedge pclk); while (irq !== 1'b1);
    repeat (300) @(posedge pclk);
    chk(32'(npulse - n0), 32'h1, "one pulse");
    chk(32'(analog.sample), 32'h0, "halted");
    apb(1'b0, `SARSEQ_OFF_INT_STAT, 32'h0);
    chk(rd & 32'h2, 32'h2, "sweep flag");
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, 12'(`SARSEQ_OFF_CH_RESULT + 4 * i), 32'h0);
      chk(rd & 32'h3ff, 32'(afe.level[i]), "sweep result");
    end
    $display("test one time done");
    close_out();
  end
endmodule : sarseq_core_tb
`default_nettype wire
